// ### shared/eamc_defs.vh
// Constants for the energy accumulation mode control block
`ifndef EAMC_DEFS_VH
`define EAMC_DEFS_VH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define EAMC_IDX_ACCUMULATION_MODE_CONFIG_CFG   16'he701
`define EAMC_ADDR_ACCUMULATION_MODE_CONFIG_CFG  8'h04
`define EAMC_ADDR_STATUS       8'h08
`define EAMC_ADDR_MASK         8'h0c
`define EAMC_ADDR_PHASE_B_SEL  8'h10

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define EAMC_CFG_ACT_LSB       0
`define EAMC_CFG_REACT_LSB     2
`define EAMC_CFG_WIRE_LSB      4
`define EAMC_CFG_REVSEL_BIT    6
`define EAMC_CFG_RSVD_BIT      7
`define EAMC_CFG_RESET         8'h80
`define EAMC_ST_REV_A_BIT      6
`define EAMC_ST_REV_B_BIT      7
`define EAMC_ST_REV_C_BIT      8
`define EAMC_ST_WIDTH          9
`define EAMC_ST_MASK           9'h1c0

// ----------------------------------------------------------------
// Mode codes and data widths
// ----------------------------------------------------------------
`define EAMC_ACT_SIGNED        2'h0
`define EAMC_ACT_POSONLY       2'h1
`define EAMC_ACT_RSVD          2'h2
`define EAMC_ACT_ABS           2'h3
`define EAMC_REACT_SIGNED      2'h0
`define EAMC_REACT_RSVD        2'h1
`define EAMC_REACT_BYSIGN      2'h2
`define EAMC_REACT_ABS         2'h3
`define EAMC_WIRE_4W3V         2'h0
`define EAMC_WIRE_3WDELTA      2'h1
`define EAMC_WIRE_4W2V         2'h2
`define EAMC_WIRE_4WDELTA      2'h3
`define EAMC_DW                24

`endif

// ### rtl/eamc_phase_cond.v
// One phase of power sign conditioning for energy and pulse paths
`timescale 1ns/1ps
`default_nettype none
`include "eamc_defs.vh"

module eamc_phase_cond (
	input  wire                    clk_i,
	input  wire                    arst_n_i,
	input  wire                    valid_i,
	input  wire [1:0]              act_mode_i,
	input  wire [1:0]              react_mode_i,
	input  wire                    rev_sel_i,
	input  wire [`EAMC_DW-1:0]     tot_act_i,
	input  wire [`EAMC_DW-1:0]     fund_act_i,
	input  wire [`EAMC_DW-1:0]     fund_react_i,
	output reg  [`EAMC_DW-1:0]     tot_act_energy_o,
	output reg  [`EAMC_DW-1:0]     fund_act_energy_o,
	output reg  [`EAMC_DW-1:0]     fund_react_energy_o,
	output reg  [`EAMC_DW-1:0]     tot_act_pulse_o,
	output reg  [`EAMC_DW-1:0]     fund_act_pulse_o,
	output reg  [`EAMC_DW-1:0]     fund_react_pulse_o,
	output reg                     valid_o,
	output reg                     reverse_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Two's complement negate; most negative value saturates to max
	function [`EAMC_DW-1:0] neg;
		input [`EAMC_DW-1:0] v;
		begin
			if (v == {1'b1, {(`EAMC_DW-1){1'b0}}}) begin
				neg = {1'b0, {(`EAMC_DW-1){1'b1}}};
			end else begin
				neg = ~v + {{(`EAMC_DW-1){1'b0}}, 1'b1};
			end
		end
	endfunction

	// Active power for the energy registers
	function [`EAMC_DW-1:0] act_energy;
		input [1:0]          mode;
		input [`EAMC_DW-1:0] p;
		begin
			if (mode == `EAMC_ACT_POSONLY) begin
				act_energy = p[`EAMC_DW-1] ? {`EAMC_DW{1'b0}} : p;
			end else if (mode == `EAMC_ACT_ABS) begin
				act_energy = p[`EAMC_DW-1] ? neg(p) : p;
			end else begin
				act_energy = p;
			end
		end
	endfunction

	// Active power for the pulse path: positive-only still pulses signed
	function [`EAMC_DW-1:0] act_pulse;
		input [1:0]          mode;
		input [`EAMC_DW-1:0] p;
		begin
			if (mode == `EAMC_ACT_ABS) begin
				act_pulse = p[`EAMC_DW-1] ? neg(p) : p;
			end else begin
				act_pulse = p;
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// Reactive conditioning, same for energy and pulse paths
	// ----------------------------------------------------------------
	reg [`EAMC_DW-1:0] react_c;
	always @* begin
		case (react_mode_i)
			`EAMC_REACT_BYSIGN: react_c = fund_act_i[`EAMC_DW-1] ?
				neg(fund_react_i) : fund_react_i;
			`EAMC_REACT_ABS: react_c = fund_react_i[`EAMC_DW-1] ?
				neg(fund_react_i) : fund_react_i;
			default: react_c = fund_react_i;
		endcase
	end

	// Registered per-phase update, using only this phase's samples
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tot_act_energy_o    <= {`EAMC_DW{1'b0}};
			fund_act_energy_o   <= {`EAMC_DW{1'b0}};
			fund_react_energy_o <= {`EAMC_DW{1'b0}};
			tot_act_pulse_o     <= {`EAMC_DW{1'b0}};
			fund_act_pulse_o    <= {`EAMC_DW{1'b0}};
			fund_react_pulse_o  <= {`EAMC_DW{1'b0}};
			valid_o             <= 1'b0;
			reverse_o           <= 1'b0;
		end else begin
			valid_o <= valid_i;
			if (valid_i) begin
				tot_act_energy_o    <= act_energy(act_mode_i, tot_act_i);
				fund_act_energy_o   <= act_energy(act_mode_i, fund_act_i);
				fund_react_energy_o <= react_c;
				tot_act_pulse_o     <= act_pulse(act_mode_i, tot_act_i);
				fund_act_pulse_o    <= act_pulse(act_mode_i, fund_act_i);
				fund_react_pulse_o  <= react_c;
				reverse_o <= rev_sel_i ? fund_act_i[`EAMC_DW-1] :
					tot_act_i[`EAMC_DW-1];
			end else begin
				reverse_o <= 1'b0;
			end
		end
	end

endmodule // eamc_phase_cond

`default_nettype wire

// ### rtl/eamc_top.v
// Energy accumulation mode control with Wishbone registers and interrupt
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "eamc_defs.vh"

module eamc_top (
	input  wire                     CLK_I,
	input  wire                     ARST_N_I,
	input  wire                     WB_CYC_I,
	input  wire                     WB_STB_I,
	input  wire                     WB_WE_I,
	input  wire [7:0]               WB_ADR_I,
	input  wire [3:0]               WB_SEL_I,
	input  wire [31:0]              WB_DAT_I,
	output reg  [31:0]              WB_DAT_O,
	output reg                      WB_ACK_O,
	output reg                      WB_ERR_O,
	output reg                      IRQ_O,
	input  wire                     SAMPLE_VALID_I,
	input  wire [3*`EAMC_DW-1:0]    VOLT_I,
	input  wire [3*`EAMC_DW-1:0]    TOT_ACT_I,
	input  wire [3*`EAMC_DW-1:0]    FUND_ACT_I,
	input  wire [3*`EAMC_DW-1:0]    FUND_REACT_I,
	output reg  [`EAMC_DW-1:0]      PHASE_B_VOLT_O,
	output reg                      PHASE_B_RMS_DELTA_O,
	output wire [3*`EAMC_DW-1:0]    TOT_ACT_ENERGY_O,
	output wire [3*`EAMC_DW-1:0]    FUND_ACT_ENERGY_O,
	output wire [3*`EAMC_DW-1:0]    FUND_REACT_ENERGY_O,
	output wire [3*`EAMC_DW-1:0]    TOT_ACT_PULSE_O,
	output wire [3*`EAMC_DW-1:0]    FUND_ACT_PULSE_O,
	output wire [3*`EAMC_DW-1:0]    FUND_REACT_PULSE_O,
	output wire [2:0]               UPDATE_VALID_O
);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	reg  [7:0]                 accumulation_mode_config;
	reg  [`EAMC_ST_WIDTH-1:0]  primary_status_register;
	reg  [`EAMC_ST_WIDTH-1:0]  irq_mask;
	reg  [`EAMC_ST_WIDTH-1:0]  next_status;
	wire [2:0]                 rev_event;
	wire                       wb_req;
	wire                       wb_wr;
	reg                        addr_ok;
	reg  [31:0]                rd_mux;

	wire [1:0] active_accum_mode           = accumulation_mode_config[1:0];
	wire [1:0] reactive_accum_mode         = accumulation_mode_config[3:2];
	wire [1:0] wiring_config_select        = accumulation_mode_config[5:4];
	wire       reverse_power_source_select =
		accumulation_mode_config[`EAMC_CFG_REVSEL_BIT];

	// New request only while ack and err are low, so each cycle gets one ack or err
	assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~WB_ERR_O;
	assign wb_wr  = wb_req & WB_WE_I & addr_ok;

	// ----------------------------------------------------------------
	// Address decode and read mux
	// ----------------------------------------------------------------
	always @* begin
		addr_ok = 1'b1;
		rd_mux  = 32'h0000_0000;
		if (WB_ADR_I == `EAMC_ADDR_ACCUMULATION_MODE_CONFIG_CFG) begin
			rd_mux = {24'h00_0000, accumulation_mode_config};
		end else if (WB_ADR_I == `EAMC_ADDR_STATUS) begin
			rd_mux = {23'h00_0000, primary_status_register};
		end else if (WB_ADR_I == `EAMC_ADDR_MASK) begin
			rd_mux = {23'h00_0000, irq_mask};
		end else if (WB_ADR_I == `EAMC_ADDR_PHASE_B_SEL) begin
			rd_mux = {24'h00_0000, PHASE_B_VOLT_O[`EAMC_DW-1:`EAMC_DW-8]};
		end else begin
			addr_ok = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Bus handshake, one wait-free ack cycle after the request edge
	// ----------------------------------------------------------------
	always @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			WB_ACK_O <= 1'b0;
			WB_ERR_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= wb_req & addr_ok;
			WB_ERR_O <= wb_req & ~addr_ok;
			if (wb_req & ~WB_WE_I & addr_ok) begin
				WB_DAT_O <= rd_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration register; bit 7 is stored but steers nothing
	// ----------------------------------------------------------------
	always @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			accumulation_mode_config <= `EAMC_CFG_RESET;
		end else if (wb_wr && WB_ADR_I == `EAMC_ADDR_ACCUMULATION_MODE_CONFIG_CFG && WB_SEL_I[0]) begin
			accumulation_mode_config <= WB_DAT_I[7:0];
		end
	end

	// Mask register, same layout as status
	always @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			irq_mask <= {`EAMC_ST_WIDTH{1'b0}};
		end else if (wb_wr && WB_ADR_I == `EAMC_ADDR_MASK) begin
			if (WB_SEL_I[0]) begin
				irq_mask[7:0] <= WB_DAT_I[7:0];
			end
			if (WB_SEL_I[1]) begin
				irq_mask[8] <= WB_DAT_I[8];
			end
		end
	end

	// ----------------------------------------------------------------
	// Sticky reverse flags: write one clears, a new event wins
	// ----------------------------------------------------------------
	always @* begin
		next_status = primary_status_register;
		if (wb_wr && WB_ADR_I == `EAMC_ADDR_STATUS) begin
			if (WB_SEL_I[0]) begin
				next_status[7:0] = next_status[7:0] & ~WB_DAT_I[7:0];
			end
			if (WB_SEL_I[1]) begin
				next_status[8] = next_status[8] & ~WB_DAT_I[8];
			end
		end
		next_status[`EAMC_ST_REV_A_BIT] = next_status[`EAMC_ST_REV_A_BIT] | rev_event[0];
		next_status[`EAMC_ST_REV_B_BIT] = next_status[`EAMC_ST_REV_B_BIT] | rev_event[1];
		next_status[`EAMC_ST_REV_C_BIT] = next_status[`EAMC_ST_REV_C_BIT] | rev_event[2];
		next_status = next_status & `EAMC_ST_MASK;
	end

	always @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			primary_status_register <= {`EAMC_ST_WIDTH{1'b0}};
			IRQ_O                   <= 1'b0;
		end else begin
			primary_status_register <= next_status;
			IRQ_O                   <= |(next_status & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// Phase B voltage synthesis from the wiring selection
	// ----------------------------------------------------------------
	wire [`EAMC_DW-1:0] volt_a = VOLT_I[`EAMC_DW-1:0];
	wire [`EAMC_DW-1:0] volt_b = VOLT_I[2*`EAMC_DW-1:`EAMC_DW];
	wire [`EAMC_DW-1:0] volt_c = VOLT_I[3*`EAMC_DW-1:2*`EAMC_DW];
	reg  [`EAMC_DW-1:0] next_phase_b_volt;

	// Wraps on overflow; front end headroom keeps sums in range
	always @* begin
		case (wiring_config_select)
			`EAMC_WIRE_3WDELTA: next_phase_b_volt = volt_a - volt_c;
			`EAMC_WIRE_4W2V: next_phase_b_volt = ~volt_a + {{(`EAMC_DW-1){1'b0}}, 1'b1}
				- volt_c;
			`EAMC_WIRE_4WDELTA: next_phase_b_volt = ~volt_a +
				{{(`EAMC_DW-1){1'b0}}, 1'b1};
			default: next_phase_b_volt = volt_b;
		endcase
	end

	// Phases A and C always use their own voltage, so only B is offered
	always @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			PHASE_B_VOLT_O      <= {`EAMC_DW{1'b0}};
			PHASE_B_RMS_DELTA_O <= 1'b0;
		end else begin
			PHASE_B_VOLT_O      <= next_phase_b_volt;
			PHASE_B_RMS_DELTA_O <= (wiring_config_select == `EAMC_WIRE_3WDELTA);
		end
	end

	// ----------------------------------------------------------------
	// Per-phase sign conditioning
	// ----------------------------------------------------------------
	genvar ph;
	generate
		for (ph = 0; ph < 3; ph = ph + 1) begin : g_phase
			eamc_phase_cond u_cond (
				.clk_i               (CLK_I),
				.arst_n_i            (ARST_N_I),
				.valid_i             (SAMPLE_VALID_I),
				.act_mode_i          (active_accum_mode),
				.react_mode_i        (reactive_accum_mode),
				.rev_sel_i           (reverse_power_source_select),
				.tot_act_i           (TOT_ACT_I[ph*`EAMC_DW +: `EAMC_DW]),
				.fund_act_i          (FUND_ACT_I[ph*`EAMC_DW +: `EAMC_DW]),
				.fund_react_i        (FUND_REACT_I[ph*`EAMC_DW +: `EAMC_DW]),
				.tot_act_energy_o    (TOT_ACT_ENERGY_O[ph*`EAMC_DW +: `EAMC_DW]),
				.fund_act_energy_o   (FUND_ACT_ENERGY_O[ph*`EAMC_DW +: `EAMC_DW]),
				.fund_react_energy_o (FUND_REACT_ENERGY_O[ph*`EAMC_DW +: `EAMC_DW]),
				.tot_act_pulse_o     (TOT_ACT_PULSE_O[ph*`EAMC_DW +: `EAMC_DW]),
				.fund_act_pulse_o    (FUND_ACT_PULSE_O[ph*`EAMC_DW +: `EAMC_DW]),
				.fund_react_pulse_o  (FUND_REACT_PULSE_O[ph*`EAMC_DW +: `EAMC_DW]),
				.valid_o             (UPDATE_VALID_O[ph]),
				.reverse_o           (rev_event[ph])
			);
		end
	endgenerate

endmodule // eamc_top

`default_nettype wire

// ### sim/eamc_top_properties.sv
// Port-level checker for the energy accumulation mode block
`timescale 1ns/1ps
`default_nettype none
`include "eamc_defs.vh"
module eamc_top_properties (
	input wire logic        CLK_I,
	input wire logic        ARST_N_I,
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic [7:0]  WB_ADR_I,
	input wire logic        WB_ACK_O,
	input wire logic        WB_ERR_O,
	input wire logic        SAMPLE_VALID_I,
	input wire logic [71:0] VOLT_I,
	input wire logic [71:0] TOT_ACT_I,
	input wire logic [71:0] FUND_REACT_I,
	input wire logic [23:0] PHASE_B_VOLT_O,
	input wire logic        PHASE_B_RMS_DELTA_O,
	input wire logic [71:0] TOT_ACT_ENERGY_O,
	input wire logic [71:0] TOT_ACT_PULSE_O,
	input wire logic [71:0] FUND_REACT_ENERGY_O,
	input wire logic [71:0] FUND_REACT_PULSE_O,
	input wire logic [2:0]  UPDATE_VALID_O
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!ARST_N_I);
	// Magnitude saturates, as the most negative code has no positive twin
	function automatic logic [23:0] mag(input logic [23:0] v);
		mag = !v[23] ? v : (v == 24'h800000) ? 24'h7fffff : -v;
	endfunction
	wire unm = WB_ADR_I != `EAMC_ADDR_ACCUMULATION_MODE_CONFIG_CFG && WB_ADR_I != `EAMC_ADDR_STATUS &&
		WB_ADR_I != `EAMC_ADDR_MASK && WB_ADR_I != `EAMC_ADDR_PHASE_B_SEL;
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held too long");
	a_err_unmapped: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O && unm
		|=> WB_ERR_O && !WB_ACK_O) else $error("unmapped access not refused");
	a_update_follows: assert property (SAMPLE_VALID_I |=> UPDATE_VALID_O == 3'h7)
		else $error("update strobe missing");
	a_update_quiet: assert property (!SAMPLE_VALID_I |=> UPDATE_VALID_O == 3'h0)
		else $error("spurious update strobe");
	a_energy_held: assert property (!UPDATE_VALID_O[0] |-> $stable(TOT_ACT_ENERGY_O))
		else $error("energy moved without update");
	a_act_energy: assert property (UPDATE_VALID_O[0] |-> TOT_ACT_ENERGY_O[23:0] ==
		TOT_ACT_PULSE_O[23:0] || (TOT_ACT_PULSE_O[23] && TOT_ACT_ENERGY_O[23:0] == 24'h0))
		else $error("active energy unrelated to pulse path");
	a_act_pulse: assert property (UPDATE_VALID_O[0] |-> TOT_ACT_PULSE_O[23:0] ==
		$past(TOT_ACT_I[23:0]) || TOT_ACT_PULSE_O[23:0] == mag($past(TOT_ACT_I[23:0])))
		else $error("active pulse value wrong");
	a_react_match: assert property (UPDATE_VALID_O[0] |->
		FUND_REACT_ENERGY_O == FUND_REACT_PULSE_O) else $error("reactive paths differ");
	a_react_value: assert property (UPDATE_VALID_O[0] |-> FUND_REACT_PULSE_O[23:0] ==
		$past(FUND_REACT_I[23:0]) || FUND_REACT_PULSE_O[23:0] == -$past(FUND_REACT_I[23:0])
		|| FUND_REACT_PULSE_O[23:0] == mag($past(FUND_REACT_I[23:0])))
		else $error("reactive value wrong");
	a_b_delta: assert property (PHASE_B_RMS_DELTA_O |-> PHASE_B_VOLT_O ==
		$past(VOLT_I[23:0]) - $past(VOLT_I[71:48])) else $error("phase B not A minus C");
endmodule // eamc_top_properties
bind eamc_top eamc_top_properties u_eamc_top_properties (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ADR_I(WB_ADR_I), .WB_ACK_O(WB_ACK_O),
	.WB_ERR_O(WB_ERR_O), .SAMPLE_VALID_I(SAMPLE_VALID_I), .VOLT_I(VOLT_I),
	.TOT_ACT_I(TOT_ACT_I), .FUND_REACT_I(FUND_REACT_I), .PHASE_B_VOLT_O(PHASE_B_VOLT_O),
	.PHASE_B_RMS_DELTA_O(PHASE_B_RMS_DELTA_O), .TOT_ACT_ENERGY_O(TOT_ACT_ENERGY_O),
	.TOT_ACT_PULSE_O(TOT_ACT_PULSE_O), .FUND_REACT_ENERGY_O(FUND_REACT_ENERGY_O),
	.FUND_REACT_PULSE_O(FUND_REACT_PULSE_O), .UPDATE_VALID_O(UPDATE_VALID_O));
`default_nettype wire

// ### sim/eamc_top_test.sv
// Self-checking testbench for the energy accumulation mode block
`timescale 1ns/1ps
`default_nettype none
`include "eamc_defs.vh"
module eamc_top_test;
	logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, sv = 1'b0;
	logic [7:0]  adr = 8'h00, cfg;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dw = 32'h0, rd;
	logic [71:0] volt = 72'h0, ta = 72'h0, fa = 72'h0, fr = 72'h0;
	logic [8:0]  st, mk;
	logic [23:0] xb;
	wire  [31:0] dr;
	wire         ack, err, irq, bd;
	wire  [23:0] bv;
	wire  [71:0] tae, fae, fre, tap, fap, frp;
	wire  [2:0]  uv;
	int          fail_count = 0, n_compared = 0, cyc_n = 0;
	eamc_top u_eamc_top (.CLK_I(clk), .ARST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dw), .WB_DAT_O(dr),
		.WB_ACK_O(ack), .WB_ERR_O(err), .IRQ_O(irq), .SAMPLE_VALID_I(sv), .VOLT_I(volt),
		.TOT_ACT_I(ta), .FUND_ACT_I(fa), .FUND_REACT_I(fr), .PHASE_B_VOLT_O(bv),
		.PHASE_B_RMS_DELTA_O(bd), .TOT_ACT_ENERGY_O(tae), .FUND_ACT_ENERGY_O(fae),
		.FUND_REACT_ENERGY_O(fre), .TOT_ACT_PULSE_O(tap), .FUND_ACT_PULSE_O(fap),
		.FUND_REACT_PULSE_O(frp), .UPDATE_VALID_O(uv));
	// ----------------------------------------
	// Clock, timeout and helpers
	// ----------------------------------------
	always #4 clk = ~clk;
	// Cut a hang short well past the expected run of a few thousand cycles
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [71:0] got, input logic [71:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// Negate with saturation, the most negative code has no positive twin
	function automatic logic [23:0] ngs(input logic [23:0] v);
		ngs = (v == 24'h800000) ? 24'h7fffff : -v;
	endfunction
	function automatic logic [23:0] mag(input logic [23:0] v);
		mag = v[23] ? ngs(v) : v;
	endfunction
	function automatic logic [23:0] actp(input logic [1:0] m, input logic [23:0] x);
		actp = (m == 2'h3) ? mag(x) : x;
	endfunction
	function automatic logic [23:0] acte(input logic [1:0] m, input logic [23:0] x);
		acte = (m == 2'h1 && x[23]) ? 24'h0 : actp(m, x);
	endfunction
	function automatic logic [23:0] r24();
		case ($urandom % 6)
			0: r24 = 24'h800000;
			1: r24 = 24'h000000;
			2: r24 = 24'h7fffff;
			default: r24 = 24'($urandom);
		endcase
	endfunction
	// Classic single Wishbone cycle; waits for ack or err, then releases
	// Only the bench timeout ends a wait that never gets an answer
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d, input logic e);
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; dw <= d;
		do begin
			@(posedge clk);
		end while (!(ack === 1'b1 || err === 1'b1));
		rd = dr;
		chk({ack, err}, {!e, e}, "bus answer");
		cyc <= 1'b0; stb <= 1'b0;
	endtask
	// One sample on all phases, checked one cycle later
	task automatic smp(input logic [7:0] c);
		logic [71:0] v, t, f, q, xte, xfe, xtp, xfp, xr;
		for (int p = 0; p < 3; p++) begin
			t[p*24+:24] = r24();
			f[p*24+:24] = r24();
			q[p*24+:24] = r24();
			v[p*24+:24] = 24'($urandom);
			xte[p*24+:24] = acte(c[1:0], t[p*24+:24]);
			xfe[p*24+:24] = acte(c[1:0], f[p*24+:24]);
			xtp[p*24+:24] = actp(c[1:0], t[p*24+:24]);
			xfp[p*24+:24] = actp(c[1:0], f[p*24+:24]);
			xr[p*24+:24] = (c[3:2] == 2'h3) ? mag(q[p*24+:24]) :
				(c[3:2] == 2'h2 && f[p*24+23]) ? ngs(q[p*24+:24]) : q[p*24+:24];
			st[6+p] = st[6+p] | (c[6] ? f[p*24+23] : t[p*24+23]);
		end
		case (c[5:4])
			2'h0: xb = v[47:24];
			2'h1: xb = v[23:0] - v[71:48];
			2'h2: xb = -v[23:0] - v[71:48];
			default: xb = -v[23:0];
		endcase
		@(posedge clk);
		volt <= v; ta <= t; fa <= f; fr <= q; sv <= 1'b1;
		@(posedge clk);
		sv <= 1'b0;
		#1;
		chk(uv, 72'h7, "update");
		chk(tae, xte, "tot energy");
		chk(fae, xfe, "fund energy");
		chk(tap, xtp, "tot pulse");
		chk(fap, xfp, "fund pulse");
		chk(fre, xr, "react energy");
		chk(frp, xr, "react pulse");
		chk(bv, xb, "phase b volt");
		chk(bd, c[5:4] == 2'h1, "b rms delta");
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(74));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		wb(1'b0, `EAMC_ADDR_ACCUMULATION_MODE_CONFIG_CFG, 4'hf, 32'h0, 1'b0);
		chk(rd[7:0], `EAMC_CFG_RESET, "cfg reset");
		wb(1'b0, 8'h3c, 4'hf, 32'h0, 1'b1);
		wb(1'b1, `EAMC_ADDR_ACCUMULATION_MODE_CONFIG_CFG, 4'he, 32'h3f, 1'b0);
		wb(1'b0, `EAMC_ADDR_ACCUMULATION_MODE_CONFIG_CFG, 4'hf, 32'h0, 1'b0);
		chk(rd[7:0], `EAMC_CFG_RESET, "lane off");
		// Every mode, wiring code and source select, bit 7 random
		for (int i = 0; i < 128; i++) begin
			cfg = {1'($urandom), 7'(i)};
			mk = 9'($urandom) & `EAMC_ST_MASK;
			wb(1'b1, `EAMC_ADDR_ACCUMULATION_MODE_CONFIG_CFG, 4'h1, {24'h0, cfg}, 1'b0);
			wb(1'b1, `EAMC_ADDR_MASK, 4'h3, {23'h0, mk}, 1'b0);
			wb(1'b1, `EAMC_ADDR_STATUS, 4'h3, 32'h1c0, 1'b0);
			st = 9'h0;
			repeat (3) smp(cfg);
			// Voltages hold after the last sample, so the byte view still shows it
			wb(1'b0, `EAMC_ADDR_PHASE_B_SEL, 4'hf, 32'h0, 1'b0);
			chk(rd[7:0], xb[23:16], "b volt byte");
			wb(1'b0, `EAMC_ADDR_STATUS, 4'hf, 32'h0, 1'b0);
			chk(rd[8:0] & `EAMC_ST_MASK, st, "reverse flags");
			chk(irq, |(st & mk), "irq level");
			wb(1'b0, `EAMC_ADDR_ACCUMULATION_MODE_CONFIG_CFG, 4'hf, 32'h0, 1'b0);
			chk(rd[7:0], cfg, "cfg readback");
			// Clear lands on the same edge as the new reverse events: set wins
			st = 9'h0;
			fork
				smp(cfg);
				begin
					@(posedge clk);
					wb(1'b1, `EAMC_ADDR_STATUS, 4'h3, 32'h1c0, 1'b0);
				end
			join
			wb(1'b0, `EAMC_ADDR_STATUS, 4'hf, 32'h0, 1'b0);
			chk(rd[8:0] & `EAMC_ST_MASK, st, "set beats clear");
		end
		// A reset in mid-run must zero the outputs and restore the config
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk({irq, uv, bd, bv, ack, err, dr}, 72'h0, "outputs in reset");
		chk(tae | fae | fre | tap | fap | frp, 72'h0, "paths in reset");
		rst_n <= 1'b1;
		wb(1'b0, `EAMC_ADDR_ACCUMULATION_MODE_CONFIG_CFG, 4'hf, 32'h0, 1'b0);
		chk(rd[7:0], `EAMC_CFG_RESET, "cfg after reset");
		finish_test();
	end
endmodule // eamc_top_test
`default_nettype wire
